// ### rtl/ckswm_top.sv
// What this block does
// - clock stop forces fast RC, raises NMI
// - sleep halts monitor, no failure reported
// - software switches among six sources, locked
// - primary submode fixed by straps only
// - switching and monitor active only when cfg 0
// - disabled: request ignored, current shows strap
// - disabled: switch request bit stays zero
// - equal source aborts, request bit clears
// - valid start clears PLL-ready and fail flags
// - enable new source, wait startup timer
// - PLL source waits for lock first
// - count ten new-clock cycles before handover
// - done clears request, copies requested source
// - old source off unless kept enabled
// - processor never stalled during switch
//
// The implementer's own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ns
`default_nettype none
module ckswm_top
    import ckswm_pkg::*;
#(
    parameter int SETTLE = SETTLE_CYCLES,
    parameter int FAIL_LIMIT = FAIL_TICKS
)(
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // configuration straps
    input wire ckswm_cfg_s cfg,
    // oscillator and pll status
    input wire ckswm_osc_s oscStat,
    input wire logic pllLocked,
    input wire logic newClkTick,
    input wire logic sysClkTick,
    input wire logic sleepMode,
    input wire logic [3:0] keepOsc,
    // clock control outputs
    output logic [3:0] oscEnable,
    output logic pllEnable,
    output logic [2:0] sysClkSel,
    output logic [1:0] primarySubmode,
    output logic nmiReq
);

    localparam int SW = $clog2(SETTLE + 1);
    localparam logic [SW-1:0] SETTLE_LAST = SW'(SETTLE - 1);

    ckswm_state_e state;
    logic [SW-1:0] settleCnt;
    logic [2:0] curSrc;
    logic [2:0] reqSrc;
    logic swReq;
    logic failFlag;
    logic pllRdy;
    logic unlocked;
    logic failEvt;
    logic disabled;
    logic wrCtrl;
    logic wrKey;
    logic start;
    logic abort;
    logic done;
    logic newReady;
    logic [1:0] newIdx;
    logic [1:0] curIdx;

    assign disabled = cfg.switchMonitorDisable;

    // apb write strobes, taken in the access phase
    assign wrCtrl = psel && penable && pwrite && paddr == OFS_CTRL && unlocked;
    assign wrKey = psel && penable && pwrite && paddr == OFS_KEY;

    ckswm_unlock u_unlock (
        .clk(clk),
        .rst_b(rst_b),
        .keyWrite(wrKey),
        .keyData(pwdata),
        .unlocked(unlocked)
    );

    ckswm_fail_mon #(
        .LIMIT(FAIL_LIMIT)
    ) u_fail (
        .clk(clk),
        .rst_b(rst_b),
        .enable(!disabled && !sleepMode),
        .sysClkTick(sysClkTick),
        .failPulse(failEvt)
    );

    // switch decisions
    assign newIdx = srcOsc(reqSrc);
    assign curIdx = srcOsc(curSrc);
    assign start = state == SW_IDLE && swReq && srcValid(reqSrc)
        && reqSrc != curSrc && !failEvt;
    assign abort = state == SW_IDLE && swReq && !start;
    assign done = state == SW_SETTLE && newClkTick
        && settleCnt == SETTLE_LAST && !failEvt;
    // crystals must also see the startup timer expire
    assign newReady = oscStat.running[newIdx]
        && (oscStat.startupDone[newIdx] || (newIdx == 2'(OSC_PRI)
        && primarySubmode == SUB_EXT) || newIdx == 2'(OSC_FAST_RC)
        || newIdx == 2'(OSC_SLOW_RC));

    // switch sequencer; a failure abandons any switch in flight
    always_ff @(posedge clk) begin
        if (!rst_b || disabled || failEvt) begin
            state <= SW_IDLE;
        end else begin
            case (state)
                SW_IDLE: begin
                    if (start) begin
                        state <= SW_WAIT_OSC;
                    end
                end
                SW_WAIT_OSC: begin
                    if (newReady) begin
                        state <= SW_WAIT_PLL;
                    end
                end
                SW_WAIT_PLL: begin
                    if (!srcUsesPll(reqSrc) || pllRdy) begin
                        state <= SW_SETTLE;
                    end
                end
                default: begin
                    if (done) begin
                        state <= SW_IDLE;
                    end
                end
            endcase
        end
    end

    // settle counter runs on ticks of the incoming clock
    always_ff @(posedge clk) begin
        if (!rst_b || state != SW_SETTLE) begin
            settleCnt <= '0;
        end else if (newClkTick) begin
            settleCnt <= settleCnt + SW'(1);
        end
    end

    // current source; straps rule while switching is disabled
    always_ff @(posedge clk) begin
        if (!rst_b || disabled) begin
            curSrc <= cfg.initialSource;
        end else if (failEvt) begin
            curSrc <= SRC_FAST_RC;
        end else if (done) begin
            curSrc <= reqSrc;
        end
    end

    // requested source; frozen while a switch is in flight
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            reqSrc <= cfg.initialSource;
        end else if (wrCtrl && state == SW_IDLE && !swReq) begin
            reqSrc <= pwdata[REQ_LSB +: 3];
        end
    end

    // request bit: software set wins over a same-cycle hardware clear
    always_ff @(posedge clk) begin
        if (!rst_b || disabled) begin
            swReq <= 1'b0;
        end else if (wrCtrl && pwdata[SWREQ_BIT]) begin
            swReq <= 1'b1;
        end else if (abort || done || failEvt) begin
            swReq <= 1'b0;
        end
    end

    // fail flag: a failure in the start cycle still sets it
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            failFlag <= 1'b0;
        end else if (failEvt) begin
            failFlag <= 1'b1;
        end else if (start) begin
            failFlag <= 1'b0;
        end
    end

    // pll ready: start clears it, lock while the pll is enabled (current or target source) sets it
    always_ff @(posedge clk) begin
        if (!rst_b || start) begin
            pllRdy <= 1'b0;
        end else if (pllLocked && pllEnable) begin
            pllRdy <= 1'b1;
        end else if (!pllEnable) begin
            pllRdy <= 1'b0;
        end
    end

    // nmi pulse one cycle after the failure event
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            nmiReq <= 1'b0;
        end else begin
            nmiReq <= failEvt;
        end
    end

    // submode caught from straps at reset only
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            primarySubmode <= cfg.primarySubmode;
        end
    end

    // source power: current, target in flight, or kept by others
    always_comb begin
        oscEnable = keepOsc;
        oscEnable[curIdx] = 1'b1;
        if (state != SW_IDLE) begin
            oscEnable[newIdx] = 1'b1;
        end
    end
    assign pllEnable = srcUsesPll(curSrc)
        || (state != SW_IDLE && srcUsesPll(reqSrc));
    assign sysClkSel = curSrc;

    // read data sampled in the setup phase; zero-wait access
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
            if (paddr == OFS_CTRL) begin
                prdata[CUR_LSB +: 3] <= curSrc;
                prdata[REQ_LSB +: 3] <= reqSrc;
                prdata[UNLK_BIT] <= unlocked;
                prdata[FAIL_BIT] <= failFlag;
                prdata[SWREQ_BIT] <= swReq;
            end else if (paddr == OFS_STAT) begin
                prdata[PLLRDY_BIT] <= pllRdy;
                prdata[RUN_LSB +: OSC_N] <= oscStat.running;
            end else if (paddr != OFS_KEY) begin
                pslverr <= 1'b1;
            end
        end
    end
    assign pready = 1'b1;

    property p_fail_to_fast;
        @(posedge clk) disable iff (!rst_b)
        failEvt |=> nmiReq && curSrc == SRC_FAST_RC && failFlag;
    endproperty
    a_fail_to_fast: assert property (p_fail_to_fast)
        else $error("failure did not move clock to fast rc");

    property p_sleep_quiet;
        @(posedge clk) disable iff (!rst_b)
        sleepMode |-> !failEvt;
    endproperty
    a_sleep_quiet: assert property (p_sleep_quiet)
        else $error("failure reported during sleep");

    property p_disabled_src;
        @(posedge clk) disable iff (!rst_b)
        disabled ##1 disabled |-> curSrc == $past(cfg.initialSource)
            && !swReq && state == SW_IDLE;
    endproperty
    a_disabled_src: assert property (p_disabled_src)
        else $error("disabled switch did not follow straps");

    property p_redundant;
        @(posedge clk) disable iff (!rst_b)
        abort && !(wrCtrl && pwdata[SWREQ_BIT]) |=> !swReq
            && $stable(curSrc);
    endproperty
    a_redundant: assert property (p_redundant)
        else $error("redundant request not cleared");

    property p_start_clears;
        @(posedge clk) disable iff (!rst_b)
        start |=> !pllRdy && !failFlag && state == SW_WAIT_OSC;
    endproperty
    a_start_clears: assert property (p_start_clears)
        else $error("switch start left flags set");

    property p_pll_wait;
        @(posedge clk) disable iff (!rst_b)
        state == SW_WAIT_PLL && srcUsesPll(reqSrc) && !pllRdy
            && !failEvt && !disabled |=> state == SW_WAIT_PLL;
    endproperty
    a_pll_wait: assert property (p_pll_wait)
        else $error("left pll wait before lock");

    property p_handover;
        @(posedge clk) disable iff (!rst_b)
        $changed(curSrc) && !$past(failEvt) && !$past(disabled)
            && !disabled |-> $past(state) == SW_SETTLE
            && $past(settleCnt) == SETTLE_LAST && !swReq;
    endproperty
    a_handover: assert property (p_handover)
        else $error("handover without ten new-clock cycles");

    property p_done_copy;
        @(posedge clk) disable iff (!rst_b)
        done && !disabled |=> curSrc == $past(reqSrc)
            && state == SW_IDLE;
    endproperty
    a_done_copy: assert property (p_done_copy)
        else $error("done did not copy requested source");

    property p_locked_write;
        @(posedge clk) disable iff (!rst_b)
        !unlocked && psel && penable && pwrite && paddr == OFS_CTRL
            |=> $stable(reqSrc);
    endproperty
    a_locked_write: assert property (p_locked_write)
        else $error("locked control register was written");

    property p_old_off;
        @(posedge clk) disable iff (!rst_b)
        state == SW_IDLE && !keepOsc[OSC_SEC] && curIdx != 2'(OSC_SEC)
            |-> !oscEnable[OSC_SEC];
    endproperty
    a_old_off: assert property (p_old_off)
        else $error("unused secondary oscillator left enabled");

endmodule
`default_nettype wire

// ### common/ckswm_pkg.sv
package ckswm_pkg;

    // source codes held in the requested and current source fields
    localparam logic [2:0] SRC_FAST_RC = 3'h0;
    localparam logic [2:0] SRC_FAST_RC_PLL = 3'h1;
    localparam logic [2:0] SRC_PRI = 3'h2;
    localparam logic [2:0] SRC_PRI_PLL = 3'h3;
    localparam logic [2:0] SRC_SEC = 3'h4;
    localparam logic [2:0] SRC_SLOW_RC = 3'h5;

    // physical oscillator index into enable and status vectors
    localparam int OSC_FAST_RC = 0;
    localparam int OSC_PRI = 1;
    localparam int OSC_SEC = 2;
    localparam int OSC_SLOW_RC = 3;
    localparam int OSC_N = 4;

    // primary submode straps
    localparam logic [1:0] SUB_EXT = 2'h0;
    localparam logic [1:0] SUB_XTAL = 2'h1;
    localparam logic [1:0] SUB_HSXTAL = 2'h2;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STAT = 8'h04;
    localparam logic [7:0] OFS_KEY = 8'h08;

    // control register fields
    localparam int CUR_LSB = 12;
    localparam int REQ_LSB = 8;
    localparam int UNLK_BIT = 6;
    localparam int FAIL_BIT = 3;
    localparam int SWREQ_BIT = 0;
    // status register fields
    localparam int PLLRDY_BIT = 7;
    localparam int RUN_LSB = 0;

    // unlock keys, in order
    localparam logic [31:0] KEY_FIRST = 32'haa996655;
    localparam logic [31:0] KEY_SECOND = 32'h556699aa;

    // new-clock cycles counted before handover
    localparam int SETTLE_CYCLES = 10;
    // system clock periods without a tick before failure is declared
    localparam int FAIL_TICKS = 16;

    typedef enum logic [1:0] {
        SW_IDLE = 2'b00,
        SW_WAIT_OSC = 2'b01,
        SW_WAIT_PLL = 2'b11,
        SW_SETTLE = 2'b10
    } ckswm_state_e;

    typedef enum logic [1:0] {
        LK_LOCKED = 2'b00,
        LK_FIRST = 2'b01,
        LK_OPEN = 2'b11
    } ckswm_lock_e;

    typedef struct packed {
        logic switchMonitorDisable;
        logic [2:0] initialSource;
        logic [1:0] primarySubmode;
    } ckswm_cfg_s;

    typedef struct packed {
        logic [3:0] running;
        logic [3:0] startupDone;
    } ckswm_osc_s;

    function automatic logic srcUsesPll(input logic [2:0] s);
        return (s == SRC_FAST_RC_PLL) || (s == SRC_PRI_PLL);
    endfunction

    function automatic logic srcValid(input logic [2:0] s);
        return s <= SRC_SLOW_RC;
    endfunction

    function automatic logic [1:0] srcOsc(input logic [2:0] s);
        logic [1:0] r;
        r = 2'(OSC_FAST_RC);
        if (s == SRC_PRI || s == SRC_PRI_PLL) begin
            r = 2'(OSC_PRI);
        end else if (s == SRC_SEC) begin
            r = 2'(OSC_SEC);
        end else if (s == SRC_SLOW_RC) begin
            r = 2'(OSC_SLOW_RC);
        end
        return r;
    endfunction

endpackage

// ### rtl/ckswm_unlock.sv
`timescale 1ns/1ns
`default_nettype none
module ckswm_unlock
    import ckswm_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // key register writes
    input wire logic keyWrite,
    input wire logic [31:0] keyData,
    // lock state
    output logic unlocked
);

    ckswm_lock_e lockState;

    // two-key sequence; any stray write other than the first key drops back to locked
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            lockState <= LK_LOCKED;
        end else if (keyWrite) begin
            if (lockState == LK_LOCKED && keyData == KEY_FIRST) begin
                lockState <= LK_FIRST;
            end else if (lockState == LK_FIRST && keyData == KEY_SECOND) begin
                lockState <= LK_OPEN;
            end else if (keyData == KEY_FIRST) begin
                lockState <= LK_FIRST; // restart, so a retry needs no zero
            end else begin
                lockState <= LK_LOCKED;
            end
        end
    end

    assign unlocked = (lockState == LK_OPEN);

endmodule
`default_nettype wire

// ### rtl/ckswm_fail_mon.sv
`timescale 1ns/1ns
`default_nettype none
module ckswm_fail_mon
    import ckswm_pkg::*;
#(
    parameter int LIMIT = FAIL_TICKS
)(
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // watch control
    input wire logic enable,
    input wire logic sysClkTick,
    // one-cycle failure event
    output logic failPulse
);

    localparam int CW = $clog2(LIMIT + 1);
    localparam logic [CW-1:0] LAST = CW'(LIMIT - 1);

    logic [CW-1:0] idleCnt;

    // counts periods with no tick; restarts after each report
    always_ff @(posedge clk) begin
        if (!rst_b || !enable || sysClkTick || failPulse) begin
            idleCnt <= '0;
        end else begin
            idleCnt <= idleCnt + CW'(1);
        end
    end

    // disabled watch cannot report, which covers sleep
    assign failPulse = enable && !sysClkTick && (idleCnt == LAST);

endmodule
`default_nettype wire

// ### testbench/test_ckswm_top.sv
`timescale 1ns/1ns
`default_nettype none
module test_ckswm_top
    import ckswm_pkg::*;
;
    localparam int LIM = 4;
    logic clk = 0;
    logic rst_b = 0;
    logic psel = 0;
    logic penable = 0;
    logic pwrite = 0;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    ckswm_cfg_s cfg = 6'h01;
    ckswm_osc_s oscStat = 8'h11;
    logic pllLocked = 0;
    logic newClkTick = 0;
    logic sysClkTick = 0;
    logic sleepMode = 0;
    logic [3:0] keepOsc = '0;
    logic [3:0] oscEnable;
    logic pllEnable;
    logic [2:0] sysClkSel;
    logic [1:0] primarySubmode;
    logic nmiReq;
    logic tickOn = 0;
    logic [31:0] rd;
    logic err;
    int gap = 0;
    int n_fail = 0;
    int checked = 0;
    int nmiCount = 0;
    int mCur = 0;
    int order[7] = '{2, 4, 5, 0, 1, 0, 3};
    int bad[3] = '{0, 6, 7};

    ckswm_top #(.SETTLE(SETTLE_CYCLES), .FAIL_LIMIT(LIM)) uut (
        .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cfg(cfg), .oscStat(oscStat), .pllLocked(pllLocked),
        .newClkTick(newClkTick), .sysClkTick(sysClkTick),
        .sleepMode(sleepMode), .keepOsc(keepOsc),
        .oscEnable(oscEnable), .pllEnable(pllEnable),
        .sysClkSel(sysClkSel), .primarySubmode(primarySubmode),
        .nmiReq(nmiReq)
    );

    initial begin
        forever #50 clk = ~clk;
    end

    // gaps of two at most, so the monitor never trips by accident
    always @(posedge clk) begin
        if (tickOn && (gap >= 2 || $urandom % 2 == 1)) begin
            sysClkTick <= 1'b1;
            gap <= 0;
        end else begin
            sysClkTick <= 1'b0;
            gap <= gap + 1;
        end
    end

    // count interrupt pulses
    always @(posedge clk) begin
        if (nmiReq === 1'b1) begin
            nmiCount <= nmiCount + 1;
        end
    end

    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // one apb transfer; an idle edge after it keeps drives apart
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic unlock();
        apb(1'b1, OFS_KEY, KEY_FIRST);
        apb(1'b1, OFS_KEY, KEY_SECOND);
    endtask

    task automatic ticks(input int n);
        repeat (n) begin
            newClkTick <= 1'b1;
            @(posedge clk);
            newClkTick <= 1'b0;
            @(posedge clk);
        end
    endtask

    task automatic pollDone();
        for (int i = 0; i < 100; i++) begin
            apb(1'b0, OFS_CTRL, '0);
            if (rd[0] === 1'b0) break;
        end
    endtask

    task automatic doReset();
        rst_b <= 1'b0;
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
    endtask

    // expected control word from the model fields
    function automatic logic [31:0] cw(int cur, int req, int unl,
                                       int fl, int sw);
        logic [31:0] w;
        w = '0;
        w[14:12] = 3'(cur);
        w[10:8] = 3'(req);
        w[6] = 1'(unl);
        w[3] = 1'(fl);
        w[0] = 1'(sw);
        return w;
    endfunction

    function automatic int oscIdx(int s);
        return (s == 2 || s == 3) ? 1 : (s == 4) ? 2 : (s == 5) ? 3 : 0;
    endfunction

    // target held back first, so the oscillator wait (the lock wait for PLL targets) is seen to hold
    task automatic doSwitch(input int src);
        int idx;
        int old;
        logic pll;
        idx = oscIdx(src);
        old = oscIdx(mCur);
        pll = (src == 1 || src == 3);
        pllLocked <= 1'b0;
        oscStat.running[idx] <= pll;
        oscStat.startupDone[idx] <= pll;
        unlock;
        apb(1'b1, OFS_CTRL, 32'h7049 | (32'(src) << 8));
        apb(1'b1, OFS_KEY, '0);
        ticks(12);
        apb(1'b0, OFS_CTRL, '0);
        chk("pending", rd, cw(mCur, src, 0, 0, 1));
        chk("osc on", 32'(oscEnable[idx]), 32'h1);
        chk("pll on", 32'(pllEnable), 32'(pll || mCur == 1 || mCur == 3));
        apb(1'b0, OFS_STAT, '0);
        chk("pll ready low", 32'(rd[7]), 32'h0);
        pllLocked <= pll;
        oscStat.running[idx] <= 1'b1;
        oscStat.startupDone[idx] <= 1'b1;
        repeat (3) @(posedge clk);
        ticks(9);
        apb(1'b0, OFS_CTRL, '0);
        chk("settle", 32'(rd[0]), 32'h1);
        ticks(1);
        apb(1'b0, OFS_CTRL, '0);
        chk("done", rd, cw(src, src, 0, 0, 0));
        chk("select", 32'(sysClkSel), 32'(src));
        chk("pll after", 32'(pllEnable), 32'(pll));
        if (old != idx) begin
            chk("old osc", 32'(oscEnable[old]), 32'(keepOsc[old]));
        end
        mCur = src;
    endtask

    initial begin
        repeat (5000) @(posedge clk);
        n_fail++;
        end_of_test();
    end

    initial begin
        void'($urandom(28970));
        keepOsc <= 4'($urandom);
        tickOn <= 1'b1;
        doReset();
        apb(1'b0, OFS_CTRL, '0);
        chk("ctrl reset", rd, cw(0, 0, 0, 0, 0));
        chk("submode", 32'(primarySubmode), 32'(SUB_XTAL));
        apb(1'b0, 8'h0c, '0);
        chk("unmapped err", 32'(err), 32'h1);
        chk("unmapped data", rd, 32'h0);
        $display("test reset done");
        // a wrong key between the two keys must leave it locked
        apb(1'b1, OFS_KEY, KEY_FIRST);
        apb(1'b1, OFS_KEY, KEY_FIRST ^ (32'($urandom) | 32'h1));
        apb(1'b1, OFS_KEY, KEY_SECOND);
        apb(1'b1, OFS_CTRL, 32'h7249);
        apb(1'b0, OFS_CTRL, '0);
        chk("locked", rd, cw(0, 0, 0, 0, 0));
        unlock();
        apb(1'b0, OFS_CTRL, '0);
        chk("unlocked", rd, cw(0, 0, 1, 0, 0));
        apb(1'b1, OFS_KEY, '0);
        $display("test lock done");
        foreach (bad[i]) begin
            unlock();
            apb(1'b1, OFS_CTRL, 32'h7049 | (32'(bad[i]) << 8));
            pollDone();
            chk("abort go", 32'(rd[0]), 32'h0);
            chk("abort cur", 32'(rd[14:12]), 32'h0);
        end
        apb(1'b1, OFS_KEY, '0);
        $display("test redundant done");
        foreach (order[i]) begin
            doSwitch(order[i]);
        end
        $display("test switch done");
        // stopped clock: silent in sleep, then one interrupt
        sleepMode <= 1'b1;
        tickOn <= 1'b0;
        repeat (3 * LIM) @(posedge clk);
        chk("sleep nmi", 32'(nmiCount), 32'h0);
        sleepMode <= 1'b0;
        // ticks resume before the restarted watch can report twice
        repeat (LIM + 1) @(posedge clk);
        tickOn <= 1'b1;
        repeat (2) @(posedge clk);
        chk("nmi", 32'(nmiCount), 32'h1);
        chk("fail select", 32'(sysClkSel), 32'h0);
        apb(1'b0, OFS_CTRL, '0);
        chk("fail flag", 32'(rd[3]), 32'h1);
        mCur = 0;
        doSwitch(2);
        $display("test fail done");
        cfg <= 6'h32;
        doReset();
        cfg.primarySubmode <= SUB_EXT;
        unlock();
        apb(1'b1, OFS_CTRL, 32'h7249);
        apb(1'b0, OFS_CTRL, '0);
        chk("off go", 32'(rd[0]), 32'h0);
        chk("off cur", 32'(rd[14:12]), 32'h4);
        chk("off select", 32'(sysClkSel), 32'h4);
        chk("submode held", 32'(primarySubmode), 32'(SUB_HSXTAL));
        tickOn <= 1'b0;
        repeat (3 * LIM) @(posedge clk);
        chk("off nmi", 32'(nmiCount), 32'h1);
        $display("test disabled done");
        end_of_test();
    end
endmodule
`default_nettype wire
